// file: irc_pkg.sv
// constants and carrier types for the inverter remote command station
package irc_pkg;

  // ****************************************
  // instruction codes (low byte of the code word)
  // ****************************************
  localparam logic [7:0] IRC_CODE_MODE_WR = 8'hFB; // operation mode write
  localparam logic [7:0] IRC_CODE_MODE_RD = 8'h7B; // operation mode read
  localparam logic [7:0] IRC_CODE_RESET = 8'hFD; // inverter reset
  localparam logic [7:0] IRC_CODE_ACCEL_RD = 8'h07; // acceleration time read
  localparam logic [7:0] IRC_CODE_ACCEL_WR = 8'h87; // acceleration time write
  localparam logic [7:0] IRC_CODE_FAULT_RD = 8'h74; // fault history 1 and 2
  localparam logic [7:0] IRC_CODE_PAGE_RD = 8'h7F; // extended page read
  localparam logic [7:0] IRC_CODE_PAGE_WR = 8'hFF; // extended page write
  localparam logic [7:0] IRC_PAGE_BASE = 8'h00; // page of parameters below 100

  // ****************************************
  // data patterns, monitor codes, reply codes
  // ****************************************
  localparam logic [15:0] IRC_DATA_NET = 16'h0000; // network operation
  localparam logic [15:0] IRC_DATA_EXT = 16'h0001; // external operation
  localparam logic [15:0] IRC_DATA_RESET = 16'h9696; // reset pattern
  localparam logic [15:0] IRC_MON_OUT_FREQ = 16'h0001; // output frequency, 0.01 Hz
  localparam logic [15:0] IRC_REPLY_OK = 16'h0000; // executed
  localparam logic [15:0] IRC_REPLY_BAD_CODE = 16'h0001; // unknown code
  localparam logic [15:0] IRC_REPLY_BAD_DATA = 16'h0002; // data out of range
  localparam logic [15:0] IRC_REPLY_BAD_MODE = 16'h0003; // refused in this mode

  // ****************************************
  // reset values and limits
  // ****************************************
  localparam logic [15:0] IRC_ACCEL_RST = 16'h0032; // 5.0 s in 0.1 s units
  localparam logic [15:0] IRC_ACCEL_MAX = 16'h0BB8; // 300.0 s in 0.1 s units
  localparam logic [15:0] IRC_FREQ_RST = 16'h0000; // 0.00 Hz
  localparam logic [15:0] IRC_ZERO16 = 16'h0000; // cleared word
  localparam logic [7:0] IRC_ZERO8 = 8'h00; // cleared byte

  // ****************************************
  // remote bit positions and mapping widths
  // ****************************************
  localparam int IRC_BIT_FREQ_RAM = 13; // frequency command / done, RAM
  localparam int IRC_BIT_FREQ_EEP = 14; // frequency command / done, EEPROM
  localparam int IRC_BIT_EXEC = 15; // instruction request / done
  localparam int IRC_NFUNC = 8; // mapped functions each way
  localparam int IRC_SELW = 3; // width of one mapping selector

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic [15:0] monitor_code; // monitor selection
    logic [15:0] freq_data_word; // set frequency, 0.01 Hz
    logic [15:0] instr_code; // instruction code
    logic [15:0] instr_data; // instruction write data
  } irc_mwr_t;

  typedef struct packed {
    logic [15:0] monitor_value; // selected monitor
    logic [15:0] reply_code; // result of last instruction
    logic [15:0] read_data; // instruction read data
  } irc_mrr_t;

  typedef enum logic {IRC_IDLE, IRC_EXEC} irc_state_t;

endpackage : irc_pkg

// file: irc_station.sv
// remote command station: instruction, frequency, reset and bit mapping logic
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RL1] mode write code, zero data selects network
// [RL2] reply code placed after every instruction
// [RL3] output frequency monitor in 0.01 Hz
// [RL4] accel time read returns current value
// [RL5] accel time write stores 0.1 s units
// [RL6] master sets page before high parameters
// [RL7] frequency word taken in 0.01 Hz
// [RL8] master waits done and zero reply
// [RL9] RAM and EEPROM commands, own done flags
// [RL10] one EEPROM write per command turn-on
// [RL11] frequency changes ignored while EEPROM command on
// [RL12] fault read returns records one and two
// [RL13] remote bits mapped to input functions, configurable
// [RL14] status bits mapped from output functions, configurable
// [RL15] reset request bit only honoured at fault
// [RL16] reset code needs network or startup mode
// [RL17] one execution per request rising edge
module irc_station
  import irc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] remote_out_bits,
  input wire logic fault_reset_request_bit,
  input wire irc_mwr_t master_write_registers,
  input wire logic [15:0] output_freq,
  input wire logic fault_present,
  input wire logic [7:0] fault_rec1,
  input wire logic [7:0] fault_rec2,
  input wire logic [15:0] startup_mode_param,
  input wire logic [7:0] status_src,
  input wire logic [23:0] in_func_sel,
  input wire logic [7:0] in_func_net_en,
  input wire logic [23:0] out_func_sel,
  output irc_mrr_t master_read_registers,
  output logic [15:0] remote_in_bits,
  output logic [7:0] input_functions,
  output logic net_mode,
  output logic [7:0] ext_page,
  output logic [15:0] accel_time_param,
  output logic [15:0] set_freq,
  output logic eeprom_write,
  output logic [15:0] eeprom_data,
  output logic inverter_reset
);

  // ****************************************
  // state
  // ****************************************
  irc_state_t state; // instruction sequencer
  irc_state_t next_state;
  logic exec_prev; // last sample of the request bit
  logic ram_prev; // last sample of the RAM command
  logic eep_prev; // last sample of the EEPROM command
  logic frst_prev; // last sample of the reset request bit
  logic [15:0] lat_code; // code caught at request edge
  logic [15:0] lat_data; // data caught at request edge
  logic [15:0] next_lat_code;
  logic [15:0] next_lat_data;
  irc_mrr_t next_mrr;
  logic [15:0] next_remote_in;
  logic [7:0] next_in_func;
  logic next_net_mode;
  logic [7:0] next_page;
  logic [15:0] next_accel;
  logic [15:0] next_freq;
  logic next_eeprom_write;
  logic [15:0] next_eeprom_data;
  logic next_inv_reset;
  logic next_done_exec;
  logic done_exec; // instruction done, held while request on
  logic next_done_ram;
  logic done_ram; // RAM frequency done
  logic next_done_eep;
  logic done_eep; // EEPROM frequency done
  logic [7:0] func_raw; // mapped input functions, combinational
  logic [7:0] stat_raw; // mapped status bits, combinational

  // request edges; all inputs come from link logic on core_clk
  logic exec_rise;
  logic ram_rise;
  logic eep_rise;
  logic frst_rise;
  assign exec_rise = remote_out_bits[IRC_BIT_EXEC] & ~exec_prev;
  assign ram_rise = remote_out_bits[IRC_BIT_FREQ_RAM] & ~ram_prev;
  assign eep_rise = remote_out_bits[IRC_BIT_FREQ_EEP] & ~eep_prev;
  assign frst_rise = fault_reset_request_bit & ~frst_prev;

  // ****************************************
  // function mapping, one slice per function
  // ****************************************
  genvar gf;
  generate
    for (gf = 0; gf < IRC_NFUNC; gf++)
    begin : g_map
      // input function gf: any remote bit steered to it, if net may drive it
      always_comb
      begin
        func_raw[gf] = 1'b0;
        for (int i = 0; i < IRC_NFUNC; i++)
        begin
          if (in_func_sel[i*IRC_SELW +: IRC_SELW] == IRC_SELW'(gf))
          begin
            func_raw[gf] = func_raw[gf] | remote_out_bits[i]; // RL13
          end
        end
        func_raw[gf] = func_raw[gf] & in_func_net_en[gf]; // RL13
      end
      // status bit gf: picks one output function source
      assign stat_raw[gf] = status_src[out_func_sel[gf*IRC_SELW +: IRC_SELW]]; // RL14
    end
  endgenerate

  // ****************************************
  // next-state computation
  // ****************************************
  // instruction sequencer, frequency handshakes, reset and mapping outputs
  always_comb
  begin
    next_state = state;
    next_lat_code = lat_code;
    next_lat_data = lat_data;
    next_mrr = master_read_registers;
    next_net_mode = net_mode;
    next_page = ext_page;
    next_accel = accel_time_param;
    next_freq = set_freq;
    next_eeprom_write = 1'b0;
    next_eeprom_data = eeprom_data;
    next_inv_reset = 1'b0;
    next_done_exec = done_exec & remote_out_bits[IRC_BIT_EXEC];
    next_done_ram = done_ram & remote_out_bits[IRC_BIT_FREQ_RAM];
    next_done_eep = done_eep & remote_out_bits[IRC_BIT_FREQ_EEP];
    next_in_func = func_raw;
    // monitor follows the selected code every cycle
    if (master_write_registers.monitor_code == IRC_MON_OUT_FREQ)
    begin
      next_mrr.monitor_value = output_freq; // RL3
    end
    else
    begin
      next_mrr.monitor_value = IRC_ZERO16; // unsupported monitor reads zero
    end
    unique case (state)
      IRC_IDLE:
      begin
        // catch code and data at the edge only, so a held bit runs once
        if (exec_rise)
        begin
          next_lat_code = master_write_registers.instr_code; // RL17
          next_lat_data = master_write_registers.instr_data; // RL17
          next_state = IRC_EXEC; // RL17
        end
      end
      IRC_EXEC:
      begin
        next_state = IRC_IDLE;
        next_done_exec = remote_out_bits[IRC_BIT_EXEC];
        next_mrr.reply_code = IRC_REPLY_OK; // RL2
        if (lat_code[15:8] != IRC_ZERO8)
        begin
          next_mrr.reply_code = IRC_REPLY_BAD_CODE; // RL2
        end
        else
        begin
          unique case (lat_code[7:0])
            IRC_CODE_MODE_WR:
            begin
              if (lat_data == IRC_DATA_NET)
              begin
                next_net_mode = 1'b1; // RL1
              end
              else if (lat_data == IRC_DATA_EXT)
              begin
                next_net_mode = 1'b0;
              end
              else
              begin
                next_mrr.reply_code = IRC_REPLY_BAD_DATA;
              end
            end
            IRC_CODE_MODE_RD:
            begin
              next_mrr.read_data = net_mode ? IRC_DATA_NET : IRC_DATA_EXT;
            end
            IRC_CODE_RESET:
            begin
              // refused unless network mode or a non-zero startup mode
              if (lat_data != IRC_DATA_RESET)
              begin
                next_mrr.reply_code = IRC_REPLY_BAD_DATA;
              end
              else if (net_mode || (startup_mode_param != IRC_ZERO16))
              begin
                next_inv_reset = 1'b1; // RL16
              end
              else
              begin
                next_mrr.reply_code = IRC_REPLY_BAD_MODE; // RL16
              end
            end
            IRC_CODE_ACCEL_RD:
            begin
              // parameter codes are relative to the page; only base page lives here
              if (ext_page == IRC_PAGE_BASE)
              begin
                next_mrr.read_data = accel_time_param; // RL4
              end
              else
              begin
                next_mrr.reply_code = IRC_REPLY_BAD_CODE; // RL6
              end
            end
            IRC_CODE_ACCEL_WR:
            begin
              if (ext_page != IRC_PAGE_BASE)
              begin
                next_mrr.reply_code = IRC_REPLY_BAD_CODE; // RL6
              end
              else if (lat_data > IRC_ACCEL_MAX)
              begin
                next_mrr.reply_code = IRC_REPLY_BAD_DATA;
              end
              else
              begin
                next_accel = lat_data; // RL5
              end
            end
            IRC_CODE_FAULT_RD:
            begin
              next_mrr.read_data = {fault_rec2, fault_rec1}; // RL12
            end
            IRC_CODE_PAGE_RD:
            begin
              next_mrr.read_data = {IRC_ZERO8, ext_page};
            end
            IRC_CODE_PAGE_WR:
            begin
              if (lat_data[15:8] != IRC_ZERO8)
              begin
                next_mrr.reply_code = IRC_REPLY_BAD_DATA;
              end
              else
              begin
                next_page = lat_data[7:0]; // RL6
              end
            end
            default:
            begin
              next_mrr.reply_code = IRC_REPLY_BAD_CODE; // RL2
            end
          endcase
        end
      end
    endcase

    // RAM command: word taken at turn-on, done held while command on
    if (ram_rise)
    begin
      next_freq = master_write_registers.freq_data_word; // RL7
      next_done_ram = 1'b1; // RL9
    end
    // EEPROM command: one write at turn-on, later word changes ignored
    if (eep_rise)
    begin
      next_freq = master_write_registers.freq_data_word; // RL11
      next_eeprom_data = master_write_registers.freq_data_word; // RL10
      next_eeprom_write = 1'b1; // RL10
      next_done_eep = 1'b1; // RL9
    end
    // dedicated reset bit: edge honoured only with a fault present
    if (frst_rise && fault_present)
    begin
      next_inv_reset = 1'b1; // RL15
    end

    next_remote_in = {next_done_exec, next_done_eep, next_done_ram, 5'h00, stat_raw}; // RL14
  end

  // ****************************************
  // registers
  // ****************************************
  // registers only; reset is synchronous
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state <= IRC_IDLE;
      exec_prev <= 1'b0;
      ram_prev <= 1'b0;
      eep_prev <= 1'b0;
      frst_prev <= 1'b0;
      lat_code <= IRC_ZERO16;
      lat_data <= IRC_ZERO16;
      master_read_registers <= '0;
      remote_in_bits <= IRC_ZERO16;
      input_functions <= IRC_ZERO8;
      net_mode <= 1'b0;
      ext_page <= IRC_PAGE_BASE;
      accel_time_param <= IRC_ACCEL_RST;
      set_freq <= IRC_FREQ_RST;
      eeprom_write <= 1'b0;
      eeprom_data <= IRC_ZERO16;
      inverter_reset <= 1'b0;
      done_exec <= 1'b0;
      done_ram <= 1'b0;
      done_eep <= 1'b0;
    end
    else
    begin
      state <= next_state;
      exec_prev <= remote_out_bits[IRC_BIT_EXEC];
      ram_prev <= remote_out_bits[IRC_BIT_FREQ_RAM];
      eep_prev <= remote_out_bits[IRC_BIT_FREQ_EEP];
      frst_prev <= fault_reset_request_bit;
      lat_code <= next_lat_code;
      lat_data <= next_lat_data;
      master_read_registers <= next_mrr;
      remote_in_bits <= next_remote_in;
      input_functions <= next_in_func;
      net_mode <= next_net_mode;
      ext_page <= next_page;
      accel_time_param <= next_accel;
      set_freq <= next_freq;
      eeprom_write <= next_eeprom_write;
      eeprom_data <= next_eeprom_data;
      inverter_reset <= next_inv_reset;
      done_exec <= next_done_exec;
      done_ram <= next_done_ram;
      done_eep <= next_done_eep;
    end
  end

endmodule : irc_station
`default_nettype wire

// file: irc_station_props.sv
// concurrent checks on the remote command station ports
`timescale 1ns/1ps
`default_nettype none
module irc_station_props
  import irc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] remote_out_bits,
  input wire logic fault_reset_request_bit,
  input wire irc_mwr_t master_write_registers,
  input wire logic [15:0] output_freq,
  input wire logic fault_present,
  input wire irc_mrr_t master_read_registers,
  input wire logic [15:0] remote_in_bits,
  input wire logic [15:0] set_freq,
  input wire logic eeprom_write,
  input wire logic [15:0] eeprom_data,
  input wire logic inverter_reset
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // request edges as the station sees them
  sequence s_exec_rise;
    $rose(remote_out_bits[IRC_BIT_EXEC]);
  endsequence
  sequence s_eep_rise;
    $rose(remote_out_bits[IRC_BIT_FREQ_EEP]);
  endsequence
  a_exec_done_lat: assert property (s_exec_rise |-> ##2 remote_in_bits[IRC_BIT_EXEC])
    else $error("instruction done not on time");
  a_exec_once: assert property (remote_in_bits[15]
    && $past(remote_in_bits[15]) |-> $stable(master_read_registers.reply_code))
    else $error("reply changed while request held");
  a_done_clear: assert property ($fell(remote_out_bits[15]) |=> !remote_in_bits[15])
    else $error("instruction done stuck");
  a_ram_take: assert property ($rose(remote_out_bits[13])
    |=> remote_in_bits[13] && set_freq == $past(master_write_registers.freq_data_word))
    else $error("ram frequency not taken");
  a_eep_take: assert property (s_eep_rise
    |=> eeprom_write && remote_in_bits[14]
    && eeprom_data == $past(master_write_registers.freq_data_word))
    else $error("eeprom frequency not taken");
  // a command held through reset counts as fresh once reset lets go
  a_eep_single: assert property (eeprom_write
    |-> $past(remote_out_bits[14]) && (!$past(remote_out_bits[14], 2) || $past(rst, 2)))
    else $error("eeprom write without fresh command");
  a_eep_hold: assert property (remote_out_bits[14]
    && $past(remote_out_bits[14]) && !remote_out_bits[13] |=> $stable(set_freq))
    else $error("frequency moved under held command");
  a_mon_value: assert property (!$past(rst)
    |-> master_read_registers.monitor_value
    == ($past(master_write_registers.monitor_code) == IRC_MON_OUT_FREQ
    ? $past(output_freq) : IRC_ZERO16))
    else $error("monitor value wrong");
  a_fault_reset: assert property ($rose(fault_reset_request_bit)
    && fault_present |=> inverter_reset)
    else $error("fault reset not issued");
  a_reset_pulse: assert property (inverter_reset |=> !inverter_reset)
    else $error("reset pulse too long");
endmodule : irc_station_props
bind irc_station irc_station_props irc_station_props_i (
  .core_clk, .rst, .remote_out_bits, .fault_reset_request_bit, .master_write_registers,
  .output_freq, .fault_present, .master_read_registers, .remote_in_bits, .set_freq,
  .eeprom_write, .eeprom_data, .inverter_reset
);
`default_nettype wire

// file: irc_master_model.sv
// behavioural master controller on the far side of the station
`timescale 1ns/1ps
`default_nettype none
module irc_master_model
  import irc_pkg::*;
(
  input wire logic core_clk,
  input wire logic [15:0] remote_in_bits,
  input wire irc_mrr_t master_read_registers,
  output logic [15:0] remote_out_bits,
  output irc_mwr_t master_write_registers
);
  // ****************
  // master side tasks
  // ****************
  // idle master: no requests, registers cleared
  initial
  begin
    remote_out_bits = 16'h0000;
    master_write_registers = 64'h0;
  end
  // bounded wait for a done bit; gives up after 20 cycles and returns without flagging
  task automatic await(input int b, input logic v);
    int k;
    k = 0;
    while (remote_in_bits[b] !== v && k < 20)
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
  endtask : await
  // one instruction: hold request until done, then release
  task automatic instr(input logic [15:0] c, input logic [15:0] d,
    output logic [15:0] rep, output logic [15:0] rd);
    master_write_registers.instr_code = c;
    master_write_registers.instr_data = d;
    remote_out_bits[IRC_BIT_EXEC] = 1'b1;
    await(IRC_BIT_EXEC, 1'b1);
    rep = master_read_registers.reply_code;
    rd = master_read_registers.read_data;
    remote_out_bits[IRC_BIT_EXEC] = 1'b0;
    // stale data must not be relied on after the request
    master_write_registers.instr_data = ~d;
    await(IRC_BIT_EXEC, 1'b0);
    @(posedge core_clk);
    #1;
  endtask : instr
  // frequency command; bit stays up until drop
  task automatic freq(input int b, input logic [15:0] w);
    master_write_registers.freq_data_word = w;
    remote_out_bits[b] = 1'b1;
    await(b, 1'b1);
  endtask : freq
  task automatic drop(input int b);
    remote_out_bits[b] = 1'b0;
    await(b, 1'b0);
  endtask : drop
  // monitor code, frequency word and mappable bits
  task automatic set_aux(input logic [15:0] m, input logic [15:0] w, input logic [7:0] v);
    master_write_registers.monitor_code = m;
    master_write_registers.freq_data_word = w;
    remote_out_bits[7:0] = v;
  endtask : set_aux
endmodule : irc_master_model
`default_nettype wire

// file: tb_irc_station.sv
// self-checking testbench of the remote command station
`timescale 1ns/1ps
`default_nettype none
module tb_irc_station
  import irc_pkg::*;
;
  logic core_clk, rst, fault_reset_request_bit, fault_present, net_mode;
  logic eeprom_write, inverter_reset;
  logic [7:0] fault_rec1, fault_rec2, status_src, in_func_net_en, input_functions, ext_page;
  logic [15:0] output_freq, startup_mode_param, remote_out_bits, remote_in_bits;
  logic [15:0] accel_time_param, set_freq, eeprom_data, rep, rd;
  logic [23:0] in_func_sel, out_func_sel;
  irc_mwr_t master_write_registers;
  irc_mrr_t master_read_registers;
  int fails, tests_run, n_rst, n_eep;
  // ****************
  // harness
  // ****************
  irc_station irc_station_i (
    .core_clk, .rst, .remote_out_bits, .fault_reset_request_bit,
    .master_write_registers, .output_freq, .fault_present, .fault_rec1, .fault_rec2,
    .startup_mode_param, .status_src, .in_func_sel, .in_func_net_en, .out_func_sel,
    .master_read_registers, .remote_in_bits, .input_functions, .net_mode, .ext_page,
    .accel_time_param, .set_freq, .eeprom_write, .eeprom_data, .inverter_reset
  );
  irc_master_model irc_master_model_i (
    .core_clk, .remote_in_bits, .master_read_registers, .remote_out_bits,
    .master_write_registers
  );
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // pulse counters; old values sampled at each edge
  always @(posedge core_clk)
  begin
    if (inverter_reset === 1'b1) n_rst++;
    if (eeprom_write === 1'b1) n_eep++;
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task ex(input logic [15:0] c, input logic [15:0] d);
    irc_master_model_i.instr(c, d, rep, rd);
  endtask : ex
  task print_verdict;
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // watchdog, far beyond the roughly 90 cycles needed
  initial
  begin
    #400000;
    fails++;
    print_verdict();
  end
  // ****************
  // scenarios
  // ****************
  initial
  begin
    {rst, fault_reset_request_bit, fault_present} = 3'h4;
    {output_freq, fault_rec1, fault_rec2, startup_mode_param} = 48'h1770_21_30_0000;
    {status_src, in_func_net_en} = 16'hA5FE;
    in_func_sel = 24'hFAC688;
    out_func_sel = 24'hFAC688;
    step(5);
    rst = 1'b0;
    check(accel_time_param, IRC_ACCEL_RST);
    check({8'h00, ext_page}, 16'h0000);
    ex(IRC_CODE_MODE_WR, IRC_DATA_NET);
    check(rep, IRC_REPLY_OK);
    check({15'h0000, net_mode}, 16'h0001);
    irc_master_model_i.set_aux(IRC_MON_OUT_FREQ, 16'h0000, 8'h03);
    step(2);
    check(master_read_registers.monitor_value, 16'h1770);
    check({8'h00, input_functions}, 16'h0002);
    check({8'h00, remote_in_bits[7:0]}, 16'h00A5);
    {in_func_sel, in_func_net_en, out_func_sel} = 56'hFAC68F_FF_000000;
    step(2);
    check({8'h00, input_functions}, 16'h0082);
    check({8'h00, remote_in_bits[7:0]}, 16'h00FF);
    ex(IRC_CODE_ACCEL_WR, 16'h001E);
    check(accel_time_param, 16'h001E);
    ex(IRC_CODE_ACCEL_RD, 16'h0000);
    check(rd, 16'h001E);
    ex(IRC_CODE_ACCEL_WR, 16'h0BB9);
    check(rep, IRC_REPLY_BAD_DATA);
    check(accel_time_param, 16'h001E);
    ex(16'h0107, 16'h0000);
    check(rep, IRC_REPLY_BAD_CODE);
    ex(IRC_CODE_PAGE_WR, 16'h0001);
    check({8'h00, ext_page}, 16'h0001);
    ex(IRC_CODE_PAGE_RD, 16'h0000);
    check(rd, 16'h0001);
    ex(IRC_CODE_ACCEL_RD, 16'h0000);
    check(rep, IRC_REPLY_BAD_CODE);
    ex(IRC_CODE_PAGE_WR, 16'h0000);
    irc_master_model_i.freq(IRC_BIT_FREQ_RAM, 16'h1388);
    check(set_freq, 16'h1388);
    check({15'h0000, remote_in_bits[IRC_BIT_FREQ_RAM]}, 16'h0001);
    irc_master_model_i.drop(IRC_BIT_FREQ_RAM);
    check({15'h0000, remote_in_bits[IRC_BIT_FREQ_RAM]}, 16'h0000);
    n_eep = 0;
    irc_master_model_i.freq(IRC_BIT_FREQ_EEP, 16'h1770);
    irc_master_model_i.set_aux(IRC_MON_OUT_FREQ, 16'h0BB8, 8'h00);
    step(4);
    check(set_freq, 16'h1770);
    check(eeprom_data, 16'h1770);
    check(16'(n_eep), 16'h0001);
    check({15'h0000, remote_in_bits[IRC_BIT_FREQ_EEP]}, 16'h0001);
    irc_master_model_i.drop(IRC_BIT_FREQ_EEP);
    ex(IRC_CODE_FAULT_RD, 16'h0000);
    check(rd, 16'h3021);
    n_rst = 0;
    fault_reset_request_bit = 1'b1;
    step(2);
    fault_reset_request_bit = 1'b0;
    fault_present = 1'b1;
    step(2);
    check(16'(n_rst), 16'h0000);
    fault_reset_request_bit = 1'b1;
    step(3);
    fault_reset_request_bit = 1'b0;
    check(16'(n_rst), 16'h0001);
    fault_present = 1'b0;
    ex(IRC_CODE_RESET, 16'h0000);
    check(rep, IRC_REPLY_BAD_DATA);
    ex(IRC_CODE_RESET, IRC_DATA_RESET);
    check(rep, IRC_REPLY_OK);
    check(16'(n_rst), 16'h0002);
    ex(IRC_CODE_MODE_WR, IRC_DATA_EXT);
    check({15'h0000, net_mode}, 16'h0000);
    ex(IRC_CODE_MODE_RD, 16'h0000);
    check(rd, IRC_DATA_EXT);
    ex(IRC_CODE_RESET, IRC_DATA_RESET);
    check(rep, IRC_REPLY_BAD_MODE);
    startup_mode_param = 16'h0001;
    ex(IRC_CODE_RESET, IRC_DATA_RESET);
    check(rep, IRC_REPLY_OK);
    print_verdict();
  end
endmodule : tb_irc_station
`default_nettype wire
